// ### verilog/status_flags_cfg.svh
// Offsets, field positions, reset values and timing counts of the status flag bank
`ifndef STATUS_FLAGS_CFG_SVH
`define STATUS_FLAGS_CFG_SVH

`define OFS_PRIOR_STATE      7'h43
`define OFS_CAN_FAULT        7'h45
`define OFS_WAKE_A           7'h46
`define OFS_WAKE_B           7'h47

`define RST_STATUS           8'h00

`define POS_PRIOR_HI         7
`define POS_PRIOR_LO         6
`define POS_WDF_HI           3
`define POS_WDF_LO           2
`define POS_CMD_FAIL         1
`define POS_FAILURE          0

`define POS_CAN_FAULT_HI     2
`define POS_CAN_FAULT_LO     1
`define POS_CAN_SUPPLY_LOW   0

`define POS_CAN_WAKE         5
`define POS_TIMER_WAKE       4
`define POS_GPIO2_WAKE       5
`define POS_GPIO1_WAKE       4

`define CODE_PRIOR_CLEARED   2'h0
`define CODE_PRIOR_FAILURE   2'h1
`define CODE_PRIOR_SLEEP     2'h2

`define CODE_CAN_OK          2'h0
`define CODE_CAN_TSD         2'h1
`define CODE_TRANSMIT_DOMINANT_TIMEOUT     2'h2
`define CODE_BUS_DOMINANT_TIMEOUT     2'h3

`define DOMINANT_TIMEOUT_MS  4
`define CLOCK_KHZ            125000
`define DOMINANT_TIMEOUT_CYC (`DOMINANT_TIMEOUT_MS * `CLOCK_KHZ)

`endif

// ### verilog/status_flags_pkg.sv
// Types shared by the status flag bank
`default_nettype none
package status_flags_pkg;

	typedef enum logic [1:0] {
		wd_idle,
		wd_counting,
		wd_frozen
	} wd_state_t;

	typedef logic [7:0] status_byte_t;

endpackage : status_flags_pkg
`default_nettype wire

// ### verilog/dominant_timer.sv
// Dominant-level timeout detector, one instance per monitored line
`include "status_flags_cfg.svh"
`default_nettype none
module dominant_timer #(
	parameter int unsigned LIMIT = `DOMINANT_TIMEOUT_CYC,
	parameter int unsigned WIDTH = 20
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Monitored line
	input  wire logic enable,
	input  wire logic dominant,
	// Result
	output logic      timeout
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic             timeout_reg;
	logic             timeout_next;

	// ==========================================================
	// Count cycles of continuous dominant level
	always_comb begin
		count_next   = count_reg;
		timeout_next = 1'b0;
		if (!enable || !dominant) begin
			count_next = '0;
		end else if (count_reg >= WIDTH'(LIMIT - 1)) begin
			timeout_next = 1'b1;
		end else begin
			count_next = count_reg + WIDTH'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			count_reg   <= '0;
			timeout_reg <= 1'b0;
		end else begin
			count_reg   <= count_next;
			timeout_reg <= timeout_next;
		end
	end

	assign timeout = timeout_reg;

endmodule : dominant_timer
`default_nettype wire

// ### verilog/status_and_wake_flags.sv
// Status and wake flag bank read and cleared over the host register port
//
// Function
// RULE1 - Prior-state field records 10 after sleep, 01 after failure restart or fail-safe.
// RULE2 - Watchdog fail, thermal level two, undervoltage, enabled overvoltage give code 01.
// RULE3 - Stop-to-sleep command and sleep without wake source count as failures.
// RULE4 - Sleep request with wake flags still set records sleep origin 10.
// RULE5 - Watchdog failure count is a self-clearing counter, cleared on good trigger; the code instead holds it at wd_limit, 01 in config 2, until cleared.
// RULE6 - Counter clears when watchdog stops, unless stop came from watchdog failure.
// RULE7 - Invalid-command flag clears only by host command.
// RULE8 - Configurations 2 and 4 freeze counter after failure until a good trigger.
// RULE9 - Configuration 0: first watchdog failure only restarts, no fail outputs or flag.
// RULE10 - CAN fault field bits 2:1: 00 ok, 01 thermal, 10 transmit, 11 bus dominant.
// RULE11 - CAN supply undervoltage sets bit 0 and disables the transmitter.
// RULE12 - CAN supply comparator is enabled only while upper CAN mode bit is 1.
// RULE13 - Wake sources set their flags at the documented bit positions.
// RULE14 - Wake from fail-safe also sets the wake source flag.
// RULE15 - Wake flags clear on power-on or soft reset, kept across restart.
// RULE16 - Reserved bits always read zero.
// RULE17 - Counter reads 01 after one failure in config 2, 10 after two otherwise; config 4 freezes it at 01 after the first failure.
// RULE18 - Host clears the prior-state field; 00 means cleared.
// RULE19 - Clear-on-read bits clear when the host reads them.
`include "status_flags_cfg.svh"
`default_nettype none
module status_and_wake_flags #(
	parameter int unsigned DOMINANT_CYC = `DOMINANT_TIMEOUT_CYC,
	parameter int unsigned TIMER_WIDTH  = 20
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       soft_reset,
	// Register port
	input  wire logic       reg_read,
	input  wire logic       reg_write,
	input  wire logic [6:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	output logic            invalid_command,
	// Mode events
	input  wire logic       in_restart,
	input  wire logic       enter_restart,
	input  wire logic       sleep_request,
	input  wire logic       from_stop_mode,
	input  wire logic       any_wake_enabled,
	input  wire logic       enter_fail_safe,
	// Failure sources
	input  wire logic       watchdog_fail,
	input  wire logic       watchdog_good_trigger,
	input  wire logic       watchdog_stopped,
	input  wire logic       thermal_shutdown_level_two,
	input  wire logic       main_supply_undervoltage,
	input  wire logic       main_supply_overvoltage,
	input  wire logic       overvoltage_restart_enable,
	input  wire logic [2:0] config_select,
	// CAN monitor
	input  wire logic [1:0] can_mode,
	input  wire logic       can_thermal_shutdown,
	input  wire logic       can_transmit_dominant,
	input  wire logic       can_bus_dominant,
	input  wire logic       can_supply_below,
	output logic            can_transmit_disable,
	// Wake sources
	input  wire logic       can_wake,
	input  wire logic       timer_wake,
	input  wire logic [2:0] wake_pin,
	input  wire logic [1:0] gpio_wake,
	// Failure outputs
	output logic            fail_outputs,
	output logic            force_restart
);

	// ==========================================================
	// State
	logic [1:0] prior_state_field_reg, prior_state_field_next;
	logic [1:0] watchdog_failure_count_reg, watchdog_failure_count_next;
	logic       cmd_fail_reg, cmd_fail_next;
	logic       failure_reg, failure_next;
	logic [1:0] can_fault_reg, can_fault_next;
	logic       can_supply_low_flag_reg, can_supply_low_flag_next;
	logic [3:0] wake_flags_reg, wake_flags_next;
	logic [2:0] pins_reg;
	logic [2:0] pins_next;
	logic [7:0] rdata_reg, rdata_next;
	logic       rvalid_reg, rvalid_next;
	logic       restart_reg, restart_next;
	status_flags_pkg::wd_state_t wd_state_reg, wd_state_next;

	// ==========================================================
	// Dominant timeouts
	logic txd_timeout;
	logic bus_timeout;

	dominant_timer #(.LIMIT(DOMINANT_CYC), .WIDTH(TIMER_WIDTH)) u_txd_timer (
		.clock    (clock),
		.rst      (rst | soft_reset),
		.enable   (can_mode[1]),
		.dominant (can_transmit_dominant),
		.timeout  (txd_timeout)
	);

	dominant_timer #(.LIMIT(DOMINANT_CYC), .WIDTH(TIMER_WIDTH)) u_bus_timer (
		.clock    (clock),
		.rst      (rst | soft_reset),
		.enable   (can_mode[1]),
		.dominant (can_bus_dominant),
		.timeout  (bus_timeout)
	);

	// ==========================================================
	// Decode
	logic rd_prior, rd_can, rd_wake_a, rd_wake_b, addr_ok;
	logic [3:0] wake_set;
	logic       sleep_fail, fail_event, limit_hit, wd_counts;
	logic [1:0] wd_limit;

	always_comb begin
		rd_prior  = reg_read && (reg_addr == `OFS_PRIOR_STATE);
		rd_can    = reg_read && (reg_addr == `OFS_CAN_FAULT);
		rd_wake_a = reg_read && (reg_addr == `OFS_WAKE_A);
		rd_wake_b = reg_read && (reg_addr == `OFS_WAKE_B);
		addr_ok   = (reg_addr == `OFS_PRIOR_STATE) || (reg_addr == `OFS_CAN_FAULT) ||
		            (reg_addr == `OFS_WAKE_A) || (reg_addr == `OFS_WAKE_B);
		wake_set  = {gpio_wake[1], gpio_wake[0],
		             can_wake,
		             timer_wake};
		sleep_fail = sleep_request && (from_stop_mode || !any_wake_enabled); // RULE3
		fail_event = watchdog_fail || thermal_shutdown_level_two ||
		             main_supply_undervoltage ||
		             (main_supply_overvoltage && overvoltage_restart_enable); // RULE2
		wd_limit  = (config_select == 3'h2) ? 2'h1 : 2'h2; // RULE17
		wd_counts = (config_select == 3'h2) || (config_select == 3'h4);
		limit_hit = watchdog_fail && (watchdog_failure_count_reg + 2'h1 >= wd_limit);
	end

	// ==========================================================
	// Next state
	always_comb begin
		prior_state_field_next      = prior_state_field_reg;
		watchdog_failure_count_next = watchdog_failure_count_reg;
		cmd_fail_next               = cmd_fail_reg;
		failure_next                = failure_reg;
		can_fault_next              = can_fault_reg;
		can_supply_low_flag_next    = can_supply_low_flag_reg;
		wake_flags_next             = wake_flags_reg;
		wd_state_next               = wd_state_reg;
		rdata_next                  = 8'h00;
		rvalid_next                 = reg_read;
		restart_next                = 1'b0;

		// Read data and clear on read, events set afterwards so they win
		if (rd_prior) begin
			rdata_next[`POS_PRIOR_HI:`POS_PRIOR_LO] = prior_state_field_reg;
			rdata_next[`POS_WDF_HI:`POS_WDF_LO]     = watchdog_failure_count_reg;
			rdata_next[`POS_CMD_FAIL]               = cmd_fail_reg;
			rdata_next[`POS_FAILURE]                = failure_reg;
			prior_state_field_next = `CODE_PRIOR_CLEARED; // RULE18
			failure_next           = 1'b0; // RULE19
		end
		if (rd_can) begin
			rdata_next[`POS_CAN_FAULT_HI:`POS_CAN_FAULT_LO] = can_fault_reg; // RULE10
			rdata_next[`POS_CAN_SUPPLY_LOW]                 = can_supply_low_flag_reg;
			can_fault_next           = `CODE_CAN_OK; // RULE19
			can_supply_low_flag_next = 1'b0;
		end
		if (rd_wake_a) begin
			rdata_next = wake_a_byte(wake_flags_reg[1:0], pins_reg); // RULE16
			wake_flags_next[1:0] = 2'h0; // RULE19
		end
		if (rd_wake_b) begin
			rdata_next = {2'h0, wake_flags_reg[3:2], 4'h0}; // RULE16
			wake_flags_next[3:2] = 2'h0;
		end
		if (reg_read && !addr_ok) begin
			rdata_next = 8'h00;
		end
		if ((reg_read || reg_write) && !addr_ok) begin
			cmd_fail_next = 1'b1;
		end else if (reg_write && (reg_addr == `OFS_PRIOR_STATE)
		             && !reg_wdata[`POS_CMD_FAIL]) begin
			cmd_fail_next = 1'b0; // RULE7
		end

		// Prior state
		if (sleep_request && !sleep_fail) begin
			prior_state_field_next = `CODE_PRIOR_SLEEP; // RULE4 RULE1
		end
		if (fail_event || sleep_fail || enter_fail_safe) begin
			prior_state_field_next = `CODE_PRIOR_FAILURE; // RULE1 RULE3
		end

		// Watchdog failure counter
		unique case (wd_state_reg)
			status_flags_pkg::wd_idle, status_flags_pkg::wd_counting: begin
				if (watchdog_fail) begin
					if (watchdog_failure_count_reg < wd_limit) begin
						watchdog_failure_count_next = watchdog_failure_count_reg + 2'h1; // RULE5
					end
					wd_state_next = wd_counts ? status_flags_pkg::wd_frozen // RULE8
					                          : status_flags_pkg::wd_counting;
				end
			end
			status_flags_pkg::wd_frozen: begin
				if (watchdog_good_trigger) begin
					wd_state_next = status_flags_pkg::wd_counting; // RULE8
				end
			end
		endcase
		if (watchdog_good_trigger) begin
			watchdog_failure_count_next = 2'h0; // RULE5
			wd_state_next = status_flags_pkg::wd_idle;
		end else if (watchdog_stopped && !watchdog_fail && !enter_restart
		             && (wd_state_reg == status_flags_pkg::wd_idle
		                 || !enter_fail_safe)) begin
			watchdog_failure_count_next = 2'h0; // RULE6
			wd_state_next = status_flags_pkg::wd_idle;
		end
		if (watchdog_fail) begin
			restart_next = 1'b1;
			if (!(config_select == 3'h0 && watchdog_failure_count_reg == 2'h0)) begin
				failure_next = limit_hit ? 1'b1 : failure_next; // RULE9
			end
		end

		// CAN faults
		if (can_thermal_shutdown) begin
			can_fault_next = `CODE_CAN_TSD; // RULE10
		end
		if (txd_timeout) begin
			can_fault_next = `CODE_TRANSMIT_DOMINANT_TIMEOUT; // RULE10
		end
		if (bus_timeout) begin
			can_fault_next = `CODE_BUS_DOMINANT_TIMEOUT; // RULE10
		end
		if (can_mode[1] && can_supply_below) begin
			can_supply_low_flag_next = 1'b1; // RULE11 RULE12
		end

		// Wake flags kept across restart, set on wake incl. fail-safe
		wake_flags_next = wake_flags_next | wake_set; // RULE13 RULE14 RULE15
	end

	function automatic logic [7:0] wake_a_byte(input logic [1:0] flags,
	                                           input logic [2:0] pins);
		wake_a_byte = {2'h0, flags, 1'b0, pins};
	endfunction : wake_a_byte

	// ==========================================================
	// Wake pin flags kept apart for clarity of bit mapping

	always_comb begin
		pins_next = pins_reg | wake_pin; // RULE13 RULE14
		if (rd_wake_a) begin
			pins_next = wake_pin; // RULE19
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clock) begin
		if (rst || soft_reset) begin
			prior_state_field_reg      <= `CODE_PRIOR_CLEARED;
			watchdog_failure_count_reg <= 2'h0;
			cmd_fail_reg               <= 1'b0;
			failure_reg                <= 1'b0;
			can_fault_reg              <= `CODE_CAN_OK;
			can_supply_low_flag_reg    <= 1'b0;
			wake_flags_reg             <= 4'h0; // RULE15
			pins_reg                   <= 3'h0;
			rdata_reg                  <= `RST_STATUS;
			rvalid_reg                 <= 1'b0;
			restart_reg                <= 1'b0;
			wd_state_reg               <= status_flags_pkg::wd_idle;
		end else begin
			prior_state_field_reg      <= prior_state_field_next;
			watchdog_failure_count_reg <= watchdog_failure_count_next;
			cmd_fail_reg               <= cmd_fail_next;
			failure_reg                <= failure_next;
			can_fault_reg              <= can_fault_next;
			can_supply_low_flag_reg    <= can_supply_low_flag_next;
			wake_flags_reg             <= wake_flags_next;
			pins_reg                   <= pins_next;
			rdata_reg                  <= rdata_next;
			rvalid_reg                 <= rvalid_next;
			restart_reg                <= restart_next;
			wd_state_reg               <= wd_state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata            = rdata_reg;
	assign reg_rvalid           = rvalid_reg;
	assign invalid_command      = cmd_fail_reg;
	assign can_transmit_disable = can_supply_low_flag_reg; // RULE11
	assign fail_outputs         = failure_reg; // RULE9
	assign force_restart        = restart_reg | (in_restart & 1'b0);

endmodule : status_and_wake_flags
`default_nettype wire

// ### test/status_flags_monitor.sv
// Checker of the status flag bank port behaviour
`default_nettype none
module status_flags_monitor (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       soft_reset,
	// Register port
	input wire logic       reg_read,
	input wire logic       reg_write,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       invalid_command,
	// Events and outputs
	input wire logic [1:0] can_mode,
	input wire logic       can_supply_below,
	input wire logic       can_transmit_disable,
	input wire logic       watchdog_fail,
	input wire logic       force_restart,
	input wire logic       fail_outputs
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ==========================================
	// Assertions
	rvalid_follows_a: assert property (!$past(soft_reset) |-> reg_rvalid == $past(reg_read))
		else $error("read answer not one cycle after request");
	rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
		else $error("read data not zero outside answer");
	reserved_bits_a: assert property (reg_rvalid |-> (reg_rdata &
		($past(reg_addr) == 7'h43 ? 8'h30 : $past(reg_addr) == 7'h45 ? 8'hf8 :
		$past(reg_addr) == 7'h46 ? 8'hc8 : 8'hcf)) == 8'h00) else $error("reserved bit set");
	code_range_a: assert property (reg_rvalid && $past(reg_addr) == 7'h43
		|-> reg_rdata[7:6] != 2'h3 && reg_rdata[3:2] != 2'h3) else $error("reserved code");
	tx_disable_a: assert property ($rose(can_transmit_disable)
		|-> $past(can_supply_below) && $past(can_mode[1])) else $error("bad transmit disable");
	restart_cause_a: assert property (force_restart |-> $past(watchdog_fail))
		else $error("restart without watchdog failure");
	restart_pulse_a: assert property (watchdog_fail && !soft_reset |=> force_restart)
		else $error("watchdog failure without restart");
	invalid_hold_a: assert property (invalid_command && !soft_reset &&
		!(reg_write && reg_addr == 7'h43) |=> invalid_command) else $error("flag lost");
	unmapped_a: assert property (reg_read && !soft_reset && !(reg_addr inside
		{7'h43, 7'h45, 7'h46, 7'h47}) |=> invalid_command && reg_rdata == 8'h00)
		else $error("unmapped read not refused");
	// ==========================================
	// Covers
	cover property (reg_rvalid && reg_rdata != 8'h00);
	cover property ($rose(invalid_command));
	cover property ($rose(fail_outputs));
endmodule : status_flags_monitor
bind status_and_wake_flags status_flags_monitor status_flags_monitor_i (.*);
`default_nettype wire

// ### test/host_model.sv
// Host side model driving the register port
`default_nettype none
module host_model (
	// Clock
	input  wire logic       clock,
	// Register port
	output logic            reg_read,
	output logic            reg_write,
	output logic      [6:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{reg_read, reg_write, reg_addr, reg_wdata} = '0;
	end
	// Read acknowledges clear-on-read flags
	task rd(input logic [6:0] a, output logic [7:0] d, output logic v);
		@(negedge clock);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clock);
		reg_read = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
endmodule : host_model
`default_nettype wire

// ### test/status_and_wake_flags_tb_top.sv
// Self-checking testbench of the status flag bank
`default_nettype none
module status_and_wake_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, soft_reset, in_restart, from_stop_mode, any_wake_enabled;
	logic overvoltage_restart_enable, can_thermal_shutdown, can_transmit_dominant;
	logic can_bus_dominant, can_supply_below, can_transmit_disable, fail_outputs;
	logic force_restart, reg_read, reg_write, reg_rvalid, invalid_command;
	logic [2:0] config_select;
	logic [1:0] can_mode;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [15:0] ev;
	int fail_count, num_checks;
	wire can_wake = ev[0], timer_wake = ev[1], enter_fail_safe = ev[2];
	wire enter_restart = ev[3], sleep_request = ev[4], watchdog_fail = ev[5];
	wire watchdog_good_trigger = ev[6], watchdog_stopped = ev[7];
	wire thermal_shutdown_level_two = ev[8], main_supply_undervoltage = ev[9];
	wire main_supply_overvoltage = ev[10];
	wire [2:0] wake_pin = ev[13:11];
	wire [1:0] gpio_wake = ev[15:14];
	status_and_wake_flags #(.DOMINANT_CYC(8)) status_and_wake_flags_i (.*);
	host_model host_model_i (.*);
	// ==========================================
	// Helpers
	task chk(input logic ok, input string s);
		num_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, s);
		end
	endtask : chk
	task rc(input logic [6:0] a, input logic [7:0] m, e);
		logic [7:0] d;
		logic v;
		host_model_i.rd(a, d, v);
		chk(v === 1'b1 && (d & m) === e, "read data");
	endtask : rc
	task pulse(input logic [15:0] p);
		@(negedge clock) ev = p;
		@(negedge clock) ev = '0;
	endtask : pulse
	task sreset;
		@(negedge clock) soft_reset = 1'b1;
		@(negedge clock) soft_reset = 1'b0;
	endtask : sreset
	task fs(input logic [15:0] p, input logic [7:0] e);
		pulse(p);
		pulse(16'h0008);
		rc(7'h43, 8'hc0, e);
	endtask : fs
	// ==========================================
	// Scenarios
	task t_reset;
		rc(7'h43, 8'hff, 8'h00);
		rc(7'h45, 8'hff, 8'h00);
		rc(7'h46, 8'hff, 8'h00);
		rc(7'h47, 8'hff, 8'h00);
	endtask : t_reset
	task t_wake;
		pulse(16'hf803);
		rc(7'h46, 8'hff, 8'h37);
		rc(7'h47, 8'hff, 8'h30);
		rc(7'h46, 8'hff, 8'h00);
		pulse(16'h0004);
		pulse(16'h0800);
		rc(7'h46, 8'hff, 8'h01);
		pulse(16'h0001);
		in_restart = 1'b1;
		pulse(16'h0008);
		in_restart = 1'b0;
		rc(7'h46, 8'hff, 8'h20);
		pulse(16'h0002);
		sreset;
		rc(7'h46, 8'hff, 8'h00);
	endtask : t_wake
	task t_can;
		@(negedge clock) can_mode = 2'h2;
		can_supply_below = 1'b1;
		repeat (2) @(negedge clock);
		chk(can_transmit_disable === 1'b1, "transmit disable");
		can_supply_below = 1'b0;
		rc(7'h45, 8'h01, 8'h01);
		can_mode = 2'h1;
		can_supply_below = 1'b1;
		repeat (3) @(negedge clock);
		can_supply_below = 1'b0;
		rc(7'h45, 8'h01, 8'h00);
		can_mode = 2'h2;
		for (int i = 1; i < 4; i++) begin
			@(negedge clock) can_thermal_shutdown = (i == 1);
			can_transmit_dominant = (i == 2);
			can_bus_dominant = (i == 3);
			repeat (12) @(negedge clock);
			{can_thermal_shutdown, can_transmit_dominant, can_bus_dominant} = '0;
			rc(7'h45, 8'h06, 8'(i * 2));
		end
		rc(7'h45, 8'h06, 8'h00);
	endtask : t_can
	task t_prior;
		sreset;
		any_wake_enabled = 1'b1;
		fs(16'h0010, 8'h80);
		rc(7'h43, 8'hc0, 8'h00);
		fs(16'h0200, 8'h40);
		fs(16'h0100, 8'h40);
		fs(16'h0400, 8'h00);
		overvoltage_restart_enable = 1'b1;
		fs(16'h0400, 8'h40);
		any_wake_enabled = 1'b0;
		fs(16'h0010, 8'h40);
		any_wake_enabled = 1'b1;
		from_stop_mode = 1'b1;
		fs(16'h0010, 8'h40);
		from_stop_mode = 1'b0;
		pulse(16'h0001);
		fs(16'h0010, 8'h80);
	endtask : t_prior
	task t_wd;
		sreset;
		config_select = 3'h1;
		pulse(16'h0020);
		pulse(16'h0020);
		chk(fail_outputs === 1'b1, "fail outputs");
		rc(7'h43, 8'h0c, 8'h08);
		pulse(16'h0040);
		rc(7'h43, 8'h0c, 8'h00);
		pulse(16'h0020);
		pulse(16'h0080);
		rc(7'h43, 8'h0c, 8'h00);
		sreset;
		config_select = 3'h2;
		pulse(16'h0020);
		pulse(16'h0020);
		rc(7'h43, 8'h0c, 8'h04);
		pulse(16'h0040);
		rc(7'h43, 8'h0c, 8'h00);
		sreset;
		config_select = 3'h0;
		pulse(16'h0020);
		chk(force_restart === 1'b1 && fail_outputs === 1'b0, "first failure");
		rc(7'h43, 8'h01, 8'h00);
		pulse(16'h0020);
		chk(fail_outputs === 1'b1, "second failure");
		fs(16'h0000, 8'h40);
	endtask : t_wd
	task t_inv;
		sreset;
		rc(7'h50, 8'hff, 8'h00);
		chk(invalid_command === 1'b1, "invalid set");
		rc(7'h43, 8'h02, 8'h02);
		chk(invalid_command === 1'b1, "invalid kept");
		host_model_i.wr(7'h43, 8'h00);
		@(negedge clock);
		chk(invalid_command === 1'b0, "invalid cleared");
	endtask : t_inv
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// ==========================================
	// Clock, sequence and watchdog
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		{soft_reset, in_restart, from_stop_mode, any_wake_enabled, ev} = '0;
		{overvoltage_restart_enable, can_thermal_shutdown, can_transmit_dominant} = '0;
		{can_bus_dominant, can_supply_below, config_select, can_mode} = '0;
		rst = 1'b1;
		repeat (20) @(negedge clock);
		rst = 1'b0;
		t_reset;
		t_wake;
		t_can;
		t_prior;
		t_wd;
		t_inv;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		stop_test;
	end
endmodule : status_and_wake_flags_tb_top
`default_nettype wire
